// ===== core/t2c_pkg.sv
// constants shared by the timer control logic and its assertion checker
// Summary of operation
// (RULE1) overflow flag sets on overflow unless a serial clock select uses us
// (RULE2) external flag sets when a trigger edge causes capture or reload
// (RULE3) interrupt requested while external flag set and interrupt enabled; the code uses the sticky interrupt status bit and its mask, not the flag
// (RULE4) external flag raises no interrupt while down count enable is one
// (RULE5) receive clock select one: receiver ticks on our overflow, else other
// (RULE6) transmit clock select one: transmitter ticks on our overflow, else other
// (RULE7) trigger pin falling edges act only while trigger enable is one
// (RULE8) timer counts only while run control is one
// (RULE9) counter select zero counts clock, one counts count pin falls
// (RULE10) software keeps counter select zero in clock output use
// (RULE11) either serial clock select one forces auto reload on overflow
package t2c_pkg;

    // register addresses on the plain register port
    localparam logic [7:0] ADDR_CONTROL   = 8'hC8;
    localparam logic [7:0] ADDR_MODE      = 8'hC9;
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO  = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI  = 8'hCD;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'hCE;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'hCF;

    // control register bit positions
    localparam int CTL_OVF  = 7;
    localparam int CTL_EXT  = 6;
    localparam int CTL_RXS  = 5;
    localparam int CTL_TXS  = 4;
    localparam int CTL_EXEN = 3;
    localparam int CTL_RUN  = 2;
    localparam int CTL_CSEL = 1;
    localparam int CTL_CPRL = 0;

    // mode register and interrupt register bit positions
    localparam int MODE_DOWN_COUNT_ENABLE = 0;
    localparam int IRQ_OVF   = 0;
    localparam int IRQ_EXT   = 1;

    // reset values and widths
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam int          TIMER_WIDTH   = 16;
    localparam int          BYTE_WIDTH    = 8;

    // operating mode, one-hot
    typedef enum logic [3:0] {
        MODE_BAUD    = 4'h1,
        MODE_CAPTURE = 4'h2,
        MODE_RELOAD  = 4'h4,
        MODE_UPDOWN  = 4'h8
    } t2c_mode_t;

endpackage : t2c_pkg

// ===== core/t2c_pin_if.sv
// conditioned pin level and falling edge between pin stage and timer
interface t2c_pin_if;
    logic level;
    logic fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface : t2c_pin_if

// ===== core/t2c_pin_edge.sv
// two-flop synchroniser and falling edge detector for one pin
module t2c_pin_edge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    t2c_pin_if.src    sig
);
    logic meta;
    logic stable;
    logic prev;

    // first flop feeds only the second; edge looks at later stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta   <= 1'b1;
            stable <= 1'b1;
            prev   <= 1'b1;
        end else begin
            meta   <= pin;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign sig.level = stable;
    assign sig.fall  = prev & ~stable;
endmodule : t2c_pin_edge

// ===== core/t2c_timer.sv
// timer control and status logic with counter, reload and serial ticks
module t2c_timer #(
    parameter int WIDTH = t2c_pkg::TIMER_WIDTH
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RESET,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       COUNT_PIN,
    input  wire logic       TRIGGER_PIN,
    input  wire logic       OTHER_TIMER_OVF,
    output logic            RX_CLK_TICK,
    output logic            TX_CLK_TICK,
    output logic            TIMER_IRQ
);

    // the register map splits the count into two bytes
    if (WIDTH != 2 * t2c_pkg::BYTE_WIDTH) begin : g_width_check
        $error("t2c_timer: WIDTH must be two bytes");
    end

    // control and mode register fields
    logic overflow_flag;
    logic external_event_flag;
    logic serial_rx_clock_select;
    logic serial_tx_clock_select;
    logic external_trigger_enable;
    logic run_control;
    logic counter_select;
    logic capture_reload_select;
    logic down_count_enable;

    // counter, reload/capture value, interrupt registers
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] reload;
    logic [1:0]       irq_status;
    logic [1:0]       irq_mask;

    // decoded and combinational terms
    t2c_pkg::t2c_mode_t mode;
    logic [WIDTH-1:0]   next_count;
    logic               tick;
    logic               trig;
    logic               count_up;
    logic               wrap;
    logic               ovf_event;
    logic               ext_event;
    logic               capture_now;
    logic               set_ovf_flag;
    logic               wr_control;
    logic               wr_mode;
    logic               wr_count_lo;
    logic               wr_count_hi;
    logic               wr_reload_lo;
    logic               wr_reload_hi;
    logic               wr_irq_stat;
    logic               wr_irq_mask;
    logic [7:0]         read_value;

    // conditioned pins
    t2c_pin_if count_sig ();
    t2c_pin_if trig_sig ();

    t2c_pin_edge u_count_pin (
        .clk (CLK_SYS),
        .rst (RESET),
        .pin (COUNT_PIN),
        .sig (count_sig)
    );

    t2c_pin_edge u_trig_pin (
        .clk (CLK_SYS),
        .rst (RESET),
        .pin (TRIGGER_PIN),
        .sig (trig_sig)
    );

    // one step of the counter in the given direction
    function automatic logic [WIDTH-1:0] t2c_step(
        input logic [WIDTH-1:0] value,
        input logic             up
    );
        logic [WIDTH-1:0] one;
        one = {{(WIDTH-1){1'b0}}, 1'b1};
        if (up) begin
            return value + one;
        end
        return value - one;
    endfunction : t2c_step

    // true when the value is all ones
    function automatic logic t2c_is_top(input logic [WIDTH-1:0] value);
        return &value;
    endfunction : t2c_is_top

    // register port write decode
    always_comb begin
        wr_control   = REG_WR && (REG_ADDR == t2c_pkg::ADDR_CONTROL);
        wr_mode      = REG_WR && (REG_ADDR == t2c_pkg::ADDR_MODE);
        wr_count_lo  = REG_WR && (REG_ADDR == t2c_pkg::ADDR_COUNT_LO);
        wr_count_hi  = REG_WR && (REG_ADDR == t2c_pkg::ADDR_COUNT_HI);
        wr_reload_lo = REG_WR && (REG_ADDR == t2c_pkg::ADDR_RELOAD_LO);
        wr_reload_hi = REG_WR && (REG_ADDR == t2c_pkg::ADDR_RELOAD_HI);
        wr_irq_stat  = REG_WR && (REG_ADDR == t2c_pkg::ADDR_IRQ_STAT);
        wr_irq_mask  = REG_WR && (REG_ADDR == t2c_pkg::ADDR_IRQ_MASK);
    end

    // operating mode decode; serial use overrides capture select
    always_comb begin
        if (serial_rx_clock_select || serial_tx_clock_select) begin
            mode = t2c_pkg::MODE_BAUD;              // see RULE11
        end else if (capture_reload_select) begin
            mode = t2c_pkg::MODE_CAPTURE;
        end else if (down_count_enable) begin
            mode = t2c_pkg::MODE_UPDOWN;
        end else begin
            mode = t2c_pkg::MODE_RELOAD;
        end
    end

    // count enable and trigger qualification
    always_comb begin
        tick = run_control                                // see RULE8
            && (counter_select ? count_sig.fall : 1'b1);  // see RULE9
        trig = external_trigger_enable && trig_sig.fall;  // see RULE7
    end

    // direction follows the trigger pin level in up/down mode only
    always_comb begin
        count_up = (mode != t2c_pkg::MODE_UPDOWN) || trig_sig.level;
        if (count_up) begin
            wrap = t2c_is_top(count);
        end else begin
            wrap = (count == reload);
        end
        ovf_event = tick && wrap;
    end

    // counter next value per mode
    always_comb begin
        next_count  = count;
        ext_event   = 1'b0;
        capture_now = 1'b0;
        case (mode)
            t2c_pkg::MODE_BAUD: begin
                if (tick) begin
                    next_count = wrap ? reload               // see RULE11
                                      : t2c_step(count, 1'b1);
                end
            end
            t2c_pkg::MODE_CAPTURE: begin
                if (tick) begin
                    next_count = t2c_step(count, 1'b1);
                end
                capture_now = trig;
                ext_event   = trig;
            end
            t2c_pkg::MODE_RELOAD: begin
                if (trig) begin
                    next_count = reload;
                end else if (tick) begin
                    next_count = wrap ? reload : t2c_step(count, 1'b1);
                end
                ext_event = trig;
            end
            t2c_pkg::MODE_UPDOWN: begin
                if (tick && count_up) begin
                    next_count = wrap ? reload : t2c_step(count, 1'b1);
                end else if (tick) begin
                    next_count = wrap ? {WIDTH{1'b1}}
                                      : t2c_step(count, 1'b0);
                end
            end
            default: begin
                next_count = count;
            end
        endcase
    end

    // overflow sets the flag only outside serial clock use
    assign set_ovf_flag = ovf_event
        && !serial_rx_clock_select && !serial_tx_clock_select; // see RULE1

    // counter register; a software byte write wins over counting
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            count <= t2c_pkg::COUNT_RESET;
        end else if (wr_count_lo) begin
            count[7:0] <= REG_WDATA;
        end else if (wr_count_hi) begin
            count[WIDTH-1:8] <= REG_WDATA;
        end else begin
            count <= next_count;
        end
    end

    // reload/capture value; a capture wins over a software write
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            reload <= t2c_pkg::COUNT_RESET;
        end else if (capture_now) begin
            reload <= count;
        end else if (wr_reload_lo) begin
            reload[7:0] <= REG_WDATA;
        end else if (wr_reload_hi) begin
            reload[WIDTH-1:8] <= REG_WDATA;
        end
    end

    // control configuration bits
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            serial_rx_clock_select  <= 1'b0;
            serial_tx_clock_select  <= 1'b0;
            external_trigger_enable <= 1'b0;
            run_control             <= 1'b0;
            counter_select          <= 1'b0;
            capture_reload_select   <= 1'b0;
        end else if (wr_control) begin
            serial_rx_clock_select  <= REG_WDATA[t2c_pkg::CTL_RXS];
            serial_tx_clock_select  <= REG_WDATA[t2c_pkg::CTL_TXS];
            external_trigger_enable <= REG_WDATA[t2c_pkg::CTL_EXEN];
            run_control             <= REG_WDATA[t2c_pkg::CTL_RUN];
            counter_select          <= REG_WDATA[t2c_pkg::CTL_CSEL];
            capture_reload_select   <= REG_WDATA[t2c_pkg::CTL_CPRL];
        end
    end

    // status flags; hardware set wins over a software write
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            overflow_flag       <= 1'b0;
            external_event_flag <= 1'b0;
        end else begin
            if (set_ovf_flag) begin
                overflow_flag <= 1'b1;                  // see RULE1
            end else if (wr_control) begin
                overflow_flag <= REG_WDATA[t2c_pkg::CTL_OVF];
            end
            if (ext_event) begin
                external_event_flag <= 1'b1;            // see RULE2
            end else if (wr_control) begin
                external_event_flag <= REG_WDATA[t2c_pkg::CTL_EXT];
            end
        end
    end

    // mode register
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            down_count_enable <= 1'b0;
        end else if (wr_mode) begin
            down_count_enable <= REG_WDATA[t2c_pkg::MODE_DOWN_COUNT_ENABLE];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            irq_status <= t2c_pkg::IRQ_RESET;
        end else begin
            irq_status[t2c_pkg::IRQ_OVF] <= set_ovf_flag
                || (irq_status[t2c_pkg::IRQ_OVF]
                    && !(wr_irq_stat && REG_WDATA[t2c_pkg::IRQ_OVF]));
            irq_status[t2c_pkg::IRQ_EXT] <= ext_event
                || (irq_status[t2c_pkg::IRQ_EXT]
                    && !(wr_irq_stat && REG_WDATA[t2c_pkg::IRQ_EXT]));
        end
    end

    // interrupt enable mask
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            irq_mask <= t2c_pkg::IRQ_RESET;
        end else if (wr_irq_mask) begin
            irq_mask <= REG_WDATA[1:0];
        end
    end

    // level interrupt; external source muted in up/down counting
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            TIMER_IRQ <= 1'b0;
        end else begin
            TIMER_IRQ <= (irq_status[t2c_pkg::IRQ_OVF]
                          && irq_mask[t2c_pkg::IRQ_OVF])
                || (irq_status[t2c_pkg::IRQ_EXT]            // see RULE3
                    && irq_mask[t2c_pkg::IRQ_EXT]
                    && !down_count_enable);                 // see RULE4
        end
    end

    // serial clock ticks from our overflow or the other timer
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            RX_CLK_TICK <= 1'b0;
            TX_CLK_TICK <= 1'b0;
        end else begin
            RX_CLK_TICK <= serial_rx_clock_select ? ovf_event
                                                  : OTHER_TIMER_OVF; // see RULE5
            TX_CLK_TICK <= serial_tx_clock_select ? ovf_event
                                                  : OTHER_TIMER_OVF; // see RULE6
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (REG_ADDR)
            t2c_pkg::ADDR_CONTROL: begin
                read_value = {overflow_flag, external_event_flag,
                              serial_rx_clock_select, serial_tx_clock_select,
                              external_trigger_enable, run_control,
                              counter_select, capture_reload_select};
            end
            t2c_pkg::ADDR_MODE: begin
                read_value = {7'h00, down_count_enable};
            end
            t2c_pkg::ADDR_RELOAD_LO: begin
                read_value = reload[7:0];
            end
            t2c_pkg::ADDR_RELOAD_HI: begin
                read_value = reload[WIDTH-1:8];
            end
            t2c_pkg::ADDR_COUNT_LO: begin
                read_value = count[7:0];
            end
            t2c_pkg::ADDR_COUNT_HI: begin
                read_value = count[WIDTH-1:8];
            end
            t2c_pkg::ADDR_IRQ_STAT: begin
                read_value = {6'h00, irq_status};
            end
            t2c_pkg::ADDR_IRQ_MASK: begin
                read_value = {6'h00, irq_mask};
            end
            default: begin
                read_value = t2c_pkg::BYTE_RESET;
            end
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= t2c_pkg::BYTE_RESET;
        end else if (REG_RD) begin
            REG_RDATA <= read_value;
        end else begin
            REG_RDATA <= t2c_pkg::BYTE_RESET;
        end
    end

endmodule : t2c_timer

// ===== dv/t2c_chk.sv
// port-level assertions for the timer control logic
module t2c_chk (
    input wire logic       CLK_SYS,
    input wire logic       RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       OTHER_TIMER_OVF,
    input wire logic       RX_CLK_TICK,
    input wire logic       TX_CLK_TICK,
    input wire logic       TIMER_IRQ
);
    logic [7:0] ctl_sh;
    logic [5:0] ctl_low;
    logic [1:0] mask_sh;

    // shadow of the control byte as software wrote it
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            ctl_sh <= 8'h00;
        else if (REG_WR && REG_ADDR == t2c_pkg::ADDR_CONTROL)
            ctl_sh <= REG_WDATA;
    end

    // shadow of the interrupt mask
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            mask_sh <= 2'h0;
        else if (REG_WR && REG_ADDR == t2c_pkg::ADDR_IRQ_MASK)
            mask_sh <= REG_WDATA[1:0];
    end

    // plain control bits, flags left out
    assign ctl_low = ctl_sh[5:0];

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    AST_RD_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data not zero outside a read");
    AST_RD_UNMAPPED: assert property (REG_RD && REG_ADDR[7:3] != 5'h19
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    AST_RD_CTRL: assert property (REG_RD && REG_ADDR == 8'hC8
        |=> REG_RDATA[5:0] == $past(ctl_low))
        else $error("control bits read back wrong");
    AST_RX_OTHER: assert property (!ctl_sh[5]
        |=> RX_CLK_TICK == $past(OTHER_TIMER_OVF))
        else $error("receive tick not from other timer");
    AST_TX_OTHER: assert property (!ctl_sh[4]
        |=> TX_CLK_TICK == $past(OTHER_TIMER_OVF))
        else $error("transmit tick not from other timer");
    AST_IRQ_MASKED: assert property (mask_sh == 2'h0 |=> !TIMER_IRQ)
        else $error("interrupt with all sources masked");
    AST_IRQ_CAUSE: assert property ($rose(TIMER_IRQ) |-> mask_sh != 2'h0)
        else $error("interrupt rose without an enabled source");
    AST_IRQ_HOLD: assert property (TIMER_IRQ && !REG_WR
        && !$past(REG_WR) |=> TIMER_IRQ)
        else $error("interrupt dropped without a write");

    COV_RX: cover property (RX_CLK_TICK);
    COV_TX: cover property (TX_CLK_TICK);
    COV_IRQ: cover property ($rose(TIMER_IRQ));
endmodule : t2c_chk

bind t2c_timer t2c_chk chk_u (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .OTHER_TIMER_OVF(OTHER_TIMER_OVF), .RX_CLK_TICK(RX_CLK_TICK),
    .TX_CLK_TICK(TX_CLK_TICK), .TIMER_IRQ(TIMER_IRQ));

// ===== dv/testbench.sv
// self-checking bench for the timer control logic
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct { string name; logic [7:0] exp; } t2c_note_t;
    logic        CLK_SYS   = 1'b0;
    logic        RESET     = 1'b1;
    logic [7:0]  REG_ADDR  = 8'h00;
    logic [7:0]  REG_WDATA = 8'h00;
    logic        REG_WR    = 1'b0;
    logic        REG_RD    = 1'b0;
    logic [7:0]  REG_RDATA;
    logic        COUNT_PIN = 1'b1;
    logic        TRIGGER_PIN = 1'b1;
    logic        OTHER_TIMER_OVF = 1'b0;
    logic        RX_CLK_TICK;
    logic        TX_CLK_TICK;
    logic        TIMER_IRQ;
    logic        rd_d = 1'b0;
    logic [15:0] r;
    int          errors = 0;
    int          n_compared = 0;
    int          rx_n = 0;
    int          tx_n = 0;
    int          rx0;
    int          tx0;
    t2c_note_t   notes[$];
    t2c_note_t   nt;

    always #5 CLK_SYS = ~CLK_SYS;

    t2c_timer dut_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .COUNT_PIN(COUNT_PIN),
        .TRIGGER_PIN(TRIGGER_PIN), .OTHER_TIMER_OVF(OTHER_TIMER_OVF),
        .RX_CLK_TICK(RX_CLK_TICK), .TX_CLK_TICK(TX_CLK_TICK),
        .TIMER_IRQ(TIMER_IRQ));

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
    endtask : wr

    // the read is noted here and judged by the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK_SYS);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        notes.push_back('{name: $sformatf("reg %h", a), exp: e});
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
    endtask : rd

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(8'(a + 8'h01), v[15:8]);
    endtask : wr16

    task automatic rd16(input logic [7:0] a, input logic [15:0] v);
        rd(a, v[7:0]);
        rd(8'(a + 8'h01), v[15:8]);
    endtask : rd16

    // pin levels held long enough for the synchroniser
    task automatic cnt_falls(input int n);
        repeat (n) begin
            @(posedge CLK_SYS);
            COUNT_PIN <= 1'b0;
            repeat (3) @(posedge CLK_SYS);
            COUNT_PIN <= 1'b1;
            repeat (3) @(posedge CLK_SYS);
        end
    endtask : cnt_falls

    task automatic trig_fall();
        @(posedge CLK_SYS);
        TRIGGER_PIN <= 1'b0;
        repeat (6) @(posedge CLK_SYS);
        TRIGGER_PIN <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
    endtask : trig_fall

    task automatic other(input int n);
        repeat (n) begin
            @(posedge CLK_SYS);
            OTHER_TIMER_OVF <= 1'b1;
            @(posedge CLK_SYS);
            OTHER_TIMER_OVF <= 1'b0;
            repeat (2) @(posedge CLK_SYS);
        end
    endtask : other

    task automatic irq(input logic e);
        repeat (4) @(posedge CLK_SYS);
        #1;
        chk("irq", {7'h00, TIMER_IRQ}, {7'h00, e});
    endtask : irq

    task automatic ticks(input logic [7:0] rx_e, input logic [7:0] tx_e);
        repeat (8) @(posedge CLK_SYS);
        #1;
        chk("rx ticks", 8'(rx_n - rx0), rx_e);
        chk("tx ticks", 8'(tx_n - tx0), tx_e);
        rx0 = rx_n;
        tx0 = tx_n;
    endtask : ticks

    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // watcher: read data answered one cycle after the strobe, ticks counted
    always @(posedge CLK_SYS) begin
        rd_d <= REG_RD;
        if (RX_CLK_TICK === 1'b1) rx_n++;
        if (TX_CLK_TICK === 1'b1) tx_n++;
        if (rd_d === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            chk(nt.name, REG_RDATA, nt.exp); // tag stands at each rd call
        end
    end

    // span covers the whole sequence with wide margin
    initial begin
        repeat (8000) @(posedge CLK_SYS);
        errors++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge CLK_SYS);
        RESET <= 1'b0;
        r = 16'($urandom(32'hB633));
        r = 16'($urandom());
        // reset values and an unmapped place
        for (int a = 8'hC8; a <= 8'hCF; a++) rd(8'(a), 8'h00);
        rd(8'hC0, 8'h00);
        // overflow on the internal clock
        wr16(8'hCC, 16'hFFF0);
        wr(8'hC8, 8'h04);
        repeat (40) @(posedge CLK_SYS);
        rd(8'hC8, 8'h84);
        wr(8'hC8, 8'h00);
        rd(8'hCE, 8'h01);
        wr(8'hCF, 8'h01);
        irq(1'b1);
        wr(8'hCE, 8'h01);
        irq(1'b0);
        // stopped count holds, count pin counts only while running
        wr16(8'hCC, 16'h1234);
        repeat (20) @(posedge CLK_SYS);
        rd16(8'hCC, 16'h1234);
        wr(8'hC8, 8'h06);
        cnt_falls(5);
        wr(8'hC8, 8'h02);
        cnt_falls(2);
        rd16(8'hCC, 16'h1239);
        // serial ticks with capture select set, auto reload each two falls
        wr16(8'hCC, 16'hFFFE);
        wr16(8'hCA, 16'hFFFE);
        wr(8'hC8, 8'h27);
        rx0 = rx_n;
        tx0 = tx_n;
        cnt_falls(8);
        other(3);
        ticks(8'h04, 8'h03);
        rd(8'hC8, 8'h27);
        wr(8'hC8, 8'h17);
        cnt_falls(4);
        other(2);
        ticks(8'h02, 8'h02);
        wr(8'hCE, 8'h03);
        wr(8'hCF, 8'h02);
        // trigger ignored while disabled, then capture
        wr(8'hC8, 8'h02);
        wr16(8'hCC, r);
        wr(8'hC8, 8'h07);
        trig_fall();
        rd(8'hCE, 8'h00);
        wr(8'hC8, 8'h0F);
        trig_fall();
        rd16(8'hCA, r);
        rd(8'hC8, 8'h4F);
        irq(1'b1);
        wr(8'hCE, 8'h02);
        wr(8'hC8, 8'h0E);
        irq(1'b0);
        // trigger reload
        wr16(8'hCC, 16'h0000);
        trig_fall();
        rd16(8'hCC, r);
        rd(8'hCE, 8'h02);
        irq(1'b1);
        // a pending external flag is muted while down count is enabled
        wr(8'hC9, 8'h01);
        irq(1'b0);
        wr(8'hC9, 8'h00);
        irq(1'b1);
        wr(8'hCE, 8'h02);
        wr(8'hC8, 8'h0E);
        // up/down mode gives no interrupt from the trigger
        wr(8'hC9, 8'h01);
        trig_fall();
        rd(8'hCE, 8'h00);
        irq(1'b0);
        repeat (4) @(posedge CLK_SYS);
        conclude();
    end
endmodule : testbench
